// file: seebc_pkg.sv
// package of constants and carriers for the serial memory bus slave control
package seebc_pkg;
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned GLITCH_NS = 100;
  localparam int unsigned GLITCH_CYCLES = (GLITCH_NS * 1000) / CLK_PERIOD_PS + 1;
  localparam int unsigned PU_DELAY_MS = 1;
  // cycles per millisecond first, so the product stays inside 32 bits
  localparam int unsigned PU_DELAY_CYCLES = PU_DELAY_MS * (1000000000 / CLK_PERIOD_PS);
  localparam int unsigned WR_CYCLE_MS = 5;
  localparam int unsigned WR_CYCLE_CYCLES = WR_CYCLE_MS * (1000000000 / CLK_PERIOD_PS);
  localparam logic [3:0] DEV_TYPE_CODE = 4'hA;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam int unsigned PAGE_BYTES = 16;
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  typedef enum logic [2:0] {
    SEEBC_ST_RESET = 3'b000,
    SEEBC_ST_IDLE = 3'b001,
    SEEBC_ST_DEVADDR = 3'b010,
    SEEBC_ST_ACK = 3'b011,
    SEEBC_ST_RX = 3'b100,
    SEEBC_ST_TX = 3'b101,
    SEEBC_ST_MACK = 3'b110,
    SEEBC_ST_BUSY = 3'b111
  } seebc_state_e;

  // filtered bus view with edge strobes
  typedef struct packed {
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
  } seebc_bus_s;

  // device select straps
  typedef struct packed {
    logic device_select_bit2;
    logic device_select_bit1;
    logic device_select_bit0;
  } seebc_strap_s;
endpackage

// file: seebc_filter.sv
// synchroniser and glitch filter for one bus input
module seebc_filter #(
  parameter int unsigned CYCLES = 21
) (
  input wire logic core_clk_i, // device clock
  input wire logic rst_b_i, // sync reset, active low
  input wire logic pin_i, // raw pin level
  output logic level_o // filtered level
);
  import seebc_pkg::*;
  localparam int CW = $clog2(CYCLES + 1);
  logic meta_q;
  logic sync_q;
  logic [CW-1:0] cnt_q;

  ////////////////////////////////////////////////////////////
  // two flops before any logic reads the pin; idle bus is high
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
    end else begin
      meta_q <= pin_i;
      sync_q <= meta_q;
    end
  end

  // level must hold longer than the glitch limit before it is taken
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      cnt_q <= '0;
      level_o <= 1'b1;
    end else if (sync_q == level_o) begin
      cnt_q <= '0;
    end else if (cnt_q == CW'(CYCLES - 1)) begin
      cnt_q <= '0;
      level_o <= sync_q;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end
endmodule

// file: seebc_top.sv
// two-wire bus slave control of a small serial nonvolatile memory
module seebc_top
  import seebc_pkg::*;
#(
  parameter int unsigned PU_CYCLES = seebc_pkg::PU_DELAY_CYCLES, // ready delay in core cycles
  parameter int unsigned WR_CYCLES = seebc_pkg::WR_CYCLE_CYCLES, // write cycle in core cycles
  parameter int unsigned DEPTH = 256 // bytes of storage
) (
  input wire logic core_clk_i, // 200 MHz core clock
  input wire logic rst_b_i, // power-on detector, low below trigger
  input wire logic scl_i, // serial clock pin level
  input wire logic sda_i, // serial data pin level
  output logic sda_o, // data pin drive value, always low
  output logic sda_oe_o, // high while pulling data low
  input wire logic [2:0] dev_sel_i, // select straps, pulled low outside
  input wire logic wp_i, // write protect, pulled low outside
  output logic ready_o, // power-up delay elapsed
  output logic busy_o // internal write cycle running
);
  import seebc_pkg::*;
  localparam int PW = $clog2(PU_CYCLES + 1);
  localparam int WW = $clog2(WR_CYCLES + 1);
  localparam int AW = $clog2(DEPTH);
  localparam int PB = $clog2(PAGE_BYTES);

  seebc_bus_s bus;
  logic scl_f;
  logic sda_f;
  logic scl_d1_q;
  logic sda_d1_q;
  seebc_strap_s strap_q;
  logic wp_meta_q;
  logic wp_q;
  logic [2:0] strap_meta_q;
  seebc_state_e state_q;
  logic [2:0] bit_q;
  logic [7:0] shift_q;
  logic rw_q;
  logic addr_phase_q;
  logic wr_pend_q;
  logic wp_lock_q;
  logic ack_now_q;
  logic [AW-1:0] ptr_q;
  logic [PW-1:0] pu_cnt_q;
  logic [WW-1:0] wr_cnt_q;
  logic [7:0] mem [DEPTH];
  logic [7:0] page_q [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] page_vld_q;
  logic [AW-1:0] page_base_q;
  logic addr_hit;
  logic [PB-1:0] wr_idx;

  ////////////////////////////////////////////////////////////
  // filtered inputs; the filter also holds off short pulses
  seebc_filter #(.CYCLES(GLITCH_CYCLES)) u_scl (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .pin_i(scl_i),
    .level_o(scl_f)
  );
  seebc_filter #(.CYCLES(GLITCH_CYCLES)) u_sda (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .pin_i(sda_i),
    .level_o(sda_f)
  );

  // edge strobes from the filtered levels
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      scl_d1_q <= 1'b1;
      sda_d1_q <= 1'b1;
    end else begin
      scl_d1_q <= scl_f;
      sda_d1_q <= sda_f;
    end
  end
  assign bus.scl = scl_f;
  assign bus.sda = sda_f;
  assign bus.scl_rise = scl_f & ~scl_d1_q;
  assign bus.scl_fall = ~scl_f & scl_d1_q;
  assign bus.start = scl_f & scl_d1_q & sda_d1_q & ~sda_f;
  assign bus.stop = scl_f & scl_d1_q & ~sda_d1_q & sda_f;

  // straps and write protect are pins: two flops each
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      strap_meta_q <= 3'h0;
      strap_q <= '0;
      wp_meta_q <= 1'b0;
      wp_q <= 1'b0;
    end else begin
      strap_meta_q <= dev_sel_i;
      strap_q <= strap_meta_q;
      wp_meta_q <= wp_i;
      wp_q <= wp_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////
  // power-up ready delay
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      pu_cnt_q <= '0;
      ready_o <= 1'b0;
    end else if (!ready_o) begin
      pu_cnt_q <= pu_cnt_q + 1'b1;
      ready_o <= (pu_cnt_q == PW'(PU_CYCLES - 1));
    end
  end

  ////////////////////////////////////////////////////////////
  // protocol engine; reset clears all bus state, clock line never driven
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      state_q <= SEEBC_ST_RESET;
      bit_q <= BIT_FIRST;
      shift_q <= 8'h00;
      rw_q <= 1'b0;
      addr_phase_q <= 1'b0;
      wr_pend_q <= 1'b0;
      wp_lock_q <= 1'b0;
      ack_now_q <= 1'b0;
      ptr_q <= '0;
      page_vld_q <= '0;
      page_base_q <= '0;
      wr_cnt_q <= '0;
      busy_o <= 1'b0;
      sda_oe_o <= 1'b0;
    end else if (state_q == SEEBC_ST_RESET) begin
      if (ready_o) state_q <= SEEBC_ST_IDLE;
    end else if (state_q == SEEBC_ST_BUSY) begin
      sda_oe_o <= 1'b0;
      if (wr_cnt_q == WW'(WR_CYCLES - 1)) begin
        busy_o <= 1'b0;
        page_vld_q <= '0;
        state_q <= SEEBC_ST_IDLE;
      end else begin
        wr_cnt_q <= wr_cnt_q + 1'b1;
      end
    end else if (bus.stop) begin
      sda_oe_o <= 1'b0;
      if (wr_pend_q && !wp_lock_q && (page_vld_q != '0)) begin
        state_q <= SEEBC_ST_BUSY;
        busy_o <= 1'b1;
        wr_cnt_q <= '0;
      end else begin
        state_q <= SEEBC_ST_IDLE;
        page_vld_q <= '0;
      end
      wr_pend_q <= 1'b0;
    end else if (bus.start) begin
      state_q <= SEEBC_ST_DEVADDR;
      bit_q <= BIT_FIRST;
      sda_oe_o <= 1'b0;
      ack_now_q <= 1'b0;
      wr_pend_q <= 1'b0;
      page_vld_q <= '0;
    end else begin
      case (state_q)
        SEEBC_ST_IDLE: begin
          sda_oe_o <= 1'b0;
        end
        // receive: shift on the rise, decide the answer after the fall that ends bit eight
        SEEBC_ST_DEVADDR, SEEBC_ST_RX: begin
          if (bus.scl_rise) begin
            shift_q <= {shift_q[6:0], bus.sda};
            bit_q <= bit_q + 1'b1;
            ack_now_q <= (bit_q == BIT_LAST);
          end else if (bus.scl_fall && ack_now_q) begin
            ack_now_q <= 1'b0;
            if (state_q == SEEBC_ST_DEVADDR) begin
              if (addr_hit) begin
                rw_q <= shift_q[BIT_FIRST];
                addr_phase_q <= !shift_q[BIT_FIRST];
                sda_oe_o <= 1'b1;
                state_q <= SEEBC_ST_ACK;
              end else begin
                state_q <= SEEBC_ST_IDLE;
              end
            end else if (addr_phase_q) begin
              ptr_q <= AW'(shift_q);
              page_base_q <= AW'(shift_q);
              addr_phase_q <= 1'b0;
              sda_oe_o <= 1'b1;
              state_q <= SEEBC_ST_ACK;
            end else if (wp_lock_q) begin
              // protected: no answer, and whatever was gathered is dropped
              wr_pend_q <= 1'b0;
              page_vld_q <= '0;
              state_q <= SEEBC_ST_IDLE;
            end else begin
              page_q[ptr_q[PB-1:0]] <= shift_q;
              page_vld_q[ptr_q[PB-1:0]] <= 1'b1;
              ptr_q[PB-1:0] <= ptr_q[PB-1:0] + 1'b1; // wraps inside the page
              wr_pend_q <= 1'b1;
              sda_oe_o <= 1'b1;
              state_q <= SEEBC_ST_ACK;
            end
          end
        end
        // ninth clock: the fall that ends it releases the line or puts out the first read bit
        SEEBC_ST_ACK: begin
          if (bus.scl_fall) begin
            bit_q <= BIT_FIRST;
            if (rw_q) begin
              shift_q <= mem[ptr_q];
              sda_oe_o <= !mem[ptr_q][BIT_LAST];
              ptr_q <= ptr_q + 1'b1;
              state_q <= SEEBC_ST_TX;
            end else begin
              sda_oe_o <= 1'b0;
              wp_lock_q <= wp_q; // strobed just before each byte
              state_q <= SEEBC_ST_RX;
            end
          end
        end
        // transmit: next bit only after a fall, line released for the master's answer
        SEEBC_ST_TX: begin
          if (bus.scl_fall) begin
            if (bit_q == BIT_LAST) begin
              sda_oe_o <= 1'b0;
              state_q <= SEEBC_ST_MACK;
            end else begin
              shift_q <= {shift_q[6:0], 1'b1};
              sda_oe_o <= !shift_q[BIT_LAST - 3'h1];
              bit_q <= bit_q + 1'b1;
            end
          end
        end
        // master low on the ninth rise asks for more; high ends the read
        SEEBC_ST_MACK: begin
          if (bus.scl_rise) begin
            state_q <= bus.sda ? SEEBC_ST_IDLE : SEEBC_ST_ACK;
          end
        end
        default: begin
          sda_oe_o <= 1'b0;
        end
      endcase
    end
  end

  // own address is the fixed type code followed by the synchronised straps
  assign addr_hit = ({DEV_TYPE_CODE, strap_q} == shift_q[7:1]);
  assign wr_idx = wr_cnt_q[PB-1:0];

  ////////////////////////////////////////////////////////////
  // page commit, one byte per cycle at the head of the write cycle;
  // limitation: the write cycle must last at least a page of cycles
  always_ff @(posedge core_clk_i) begin
    if (rst_b_i && state_q == SEEBC_ST_BUSY && wr_cnt_q < WW'(PAGE_BYTES) && page_vld_q[wr_idx]) begin
      mem[{page_base_q[AW-1:PB], wr_idx}] <= page_q[wr_idx];
    end
  end

  // pin value is a constant low; only the enable moves, so the line is never driven high
  always_ff @(posedge core_clk_i) begin
    sda_o <= 1'b0;
  end
endmodule

// file: seebc_top_monitor.sv
// port assertions for the serial memory bus slave control
module seebc_top_monitor #(
  parameter int unsigned PU_CYCLES = 50, // ready delay
  parameter int unsigned WR_CYCLES = 100 // write cycle
) (
  input wire logic core_clk_i, // clock
  input wire logic rst_b_i, // reset
  input wire logic scl_i, // clock pin
  input wire logic sda_i, // data pin
  input wire logic sda_o, // drive value
  input wire logic sda_oe_o, // pull enable
  input wire logic [2:0] dev_sel_i, // straps
  input wire logic wp_i, // protect
  input wire logic ready_o, // ready
  input wire logic busy_o // write cycle
);
  int unsigned rdy_n_q;
  int unsigned bsy_n_q;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  // cycles spent waiting for ready, counted from release
  always_ff @(posedge core_clk_i) begin
    rdy_n_q <= (!rst_b_i || ready_o) ? 0 : rdy_n_q + 1;
  end
  // length of the running write cycle
  always_ff @(posedge core_clk_i) begin
    bsy_n_q <= busy_o ? bsy_n_q + 1 : 0;
  end
  property p_pull_only; sda_oe_o |-> sda_o == 1'b0; endproperty
  a_pull_only: assert property (p_pull_only) else $error("data driven high");
  property p_rst_clear; $rose(rst_b_i) |-> !ready_o && !busy_o && !sda_oe_o; endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("state kept over reset");
  property p_rdy_time; rdy_n_q <= PU_CYCLES + 1; endproperty
  a_rdy_time: assert property (p_rdy_time) else $error("ready too late");
  property p_early; !ready_o |-> !sda_oe_o; endproperty
  a_early: assert property (p_early) else $error("answer before ready");
  property p_busy_quiet; busy_o |-> !sda_oe_o; endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("pull while busy");
  property p_busy_time; bsy_n_q <= WR_CYCLES + 1; endproperty
  a_busy_time: assert property (p_busy_time) else $error("write cycle too long");
  property p_turn_low; $changed(sda_oe_o) |-> !scl_i; endproperty
  a_turn_low: assert property (p_turn_low) else $error("data changed with clock high");
  property p_stop_go; $rose(busy_o) |-> scl_i && sda_i; endproperty
  a_stop_go: assert property (p_stop_go) else $error("write began without stop");
endmodule
bind seebc_top seebc_top_monitor #(.PU_CYCLES(PU_CYCLES), .WR_CYCLES(WR_CYCLES)) u_mon (.core_clk_i, .rst_b_i,
  .scl_i, .sda_i, .sda_o, .sda_oe_o, .dev_sel_i, .wp_i, .ready_o, .busy_o);

// file: seebc_master_model.sv
// bus master model: serial clock and open-drain data
module seebc_master_model #(
  parameter int H = 50 // half bit, must outlast the input filter
) (
  input wire logic core_clk_i, // pacing clock
  input wire logic sda_i, // data line
  output logic scl_o, // serial clock
  output logic sda_pull_o // pulls data low
);
  initial begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
  end
  task automatic w(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask
  // clock idles high, only this side makes start
  task automatic start();
    sda_pull_o = 1'b0;
    w(H / 2);
    scl_o = 1'b1;
    w(H);
    sda_pull_o = 1'b1;
    w(H);
    scl_o = 1'b0;
    w(H / 2);
  endtask
  task automatic stop();
    sda_pull_o = 1'b1;
    w(H / 2);
    scl_o = 1'b1;
    w(H);
    sda_pull_o = 1'b0;
    w(H);
  endtask
  // a data pulse of 100 ns with the clock high, released as the clock drops:
  // a filter that let it through would see a start and answer the next byte
  task automatic glitch();
    sda_pull_o = 1'b1;
    w(20);
    sda_pull_o = 1'b0;
    scl_o = 1'b0;
    w(H / 2);
  endtask
  // eight bits msb first, then the ninth with data released
  task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
    for (int i = 7; i >= -1; i--) begin
      sda_pull_o = (i < 0) ? 1'b0 : !d[i];
      w(H);
      scl_o = 1'b1;
      w(H);
      if (i < 0) ack = sda_i;
      else q[i] = sda_i;
      scl_o = 1'b0;
      w(H / 2);
    end
  endtask
endmodule

// file: seebc_top_tb.sv
// self-checking bench for the serial memory bus slave control
module seebc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import seebc_pkg::*;
  localparam int PU = 50;
  localparam int WR = 2000; // long enough to poll during it
  logic core_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic wp_i = 1'b0;
  logic [2:0] dev_sel_i = 3'h0;
  logic scl, m_pull, sda_oe, sda_drv, ready, busy, sda_line, ack;
  logic [7:0] q, d0, ma;
  int n_errors = 0;
  int checks_done = 0;
  assign sda_line = m_pull ? 1'b0 : (sda_oe ? sda_drv : 1'b1); // pull-up unless pulled low
  seebc_top #(.PU_CYCLES(PU), .WR_CYCLES(WR)) dut (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .scl_i(scl),
    .sda_i(sda_line), .sda_o(sda_drv), .sda_oe_o(sda_oe), .dev_sel_i(dev_sel_i), .wp_i(wp_i), .ready_o(ready),
    .busy_o(busy));
  seebc_master_model m (.core_clk_i(core_clk_i), .sda_i(sda_line), .scl_o(scl), .sda_pull_o(m_pull));
  // 200 MHz clock
  initial begin
    forever #2.5 core_clk_i = !core_clk_i;
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic [7:0] sel(input logic rw);
    return {DEV_TYPE_CODE, dev_sel_i, rw};
  endfunction
  task automatic wait_ready();
    for (int n = 0; n < PU + 4 && ready !== 1'b1; n++) @(negedge core_clk_i);
    chk("ready", 8'h1, {7'h0, ready});
  endtask
  task automatic nack_test(input string nm, input logic [7:0] a);
    m.xfer(a, q, ack);
    chk(nm, 8'h1, {7'h0, ack});
    m.stop();
  endtask
  task automatic finish_test();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // watchdog sized well above the expected run
  initial begin
    #400000;
    n_errors++;
    finish_test();
  end
  // main sequence
  initial begin
    void'($urandom(89));
    repeat (4) @(negedge core_clk_i);
    chk("flags in reset", 8'h0, {6'h0, ready, busy});
    rst_b_i = 1'b1;
    wait_ready();
    dev_sel_i = 3'($urandom);
    ma = 8'($urandom);
    d0 = 8'($urandom);
    for (int k = 0; k < 2; k++) begin
      wp_i = k[0];
      m.start();
      m.xfer(sel(1'b0), q, ack);
      chk("addr ack", 8'h0, {7'h0, ack});
      m.xfer(ma, q, ack);
      chk("word ack", 8'h0, {7'h0, ack});
      m.xfer(d0 ^ {8{k[0]}}, q, ack);
      chk("data ack", {7'h0, wp_i}, {7'h0, ack});
      m.stop();
      repeat (40) @(negedge core_clk_i);
      chk("busy", {7'h0, !wp_i}, {7'h0, busy});
      m.start();
      m.xfer(sel(1'b0), q, ack);
      chk("poll ack", {7'h0, !wp_i}, {7'h0, ack});
      m.stop();
      for (int n = 0; n < WR && busy !== 1'b0; n++) @(negedge core_clk_i);
      chk("busy end", 8'h0, {7'h0, busy});
      m.start();
      m.xfer(sel(1'b0), q, ack);
      m.xfer(ma, q, ack);
      m.start();
      m.xfer(sel(1'b1), q, ack);
      chk("read ack", 8'h0, {7'h0, ack});
      m.xfer(8'hFF, q, ack);
      chk("read data", d0, q);
      m.stop();
    end
    m.start();
    nack_test("other strap", sel(1'b0) ^ 8'h02);
    m.glitch();
    nack_test("glitch start", sel(1'b0));
    rst_b_i = 1'b0;
    repeat (2) @(negedge core_clk_i);
    chk("flags after reset", 8'h0, {6'h0, ready, busy});
    rst_b_i = 1'b1;
    wait_ready();
    m.start();
    m.xfer(sel(1'b0), q, ack);
    chk("ack after reset", 8'h0, {7'h0, ack});
    m.stop();
    finish_test();
  end
endmodule
